// ==== rtl/counter_shift_pkg.sv ====
// Package for the four-stage counter / shift register.
// Assumes one clock domain, stages addressed as bit 0 (lowest) to bit 3 (top).
package counter_shift_pkg;
  localparam int STAGE_COUNT = 4;
  localparam int SEL_WIDTH   = 3;
  localparam logic [STAGE_COUNT-1:0] STATE_RESET = 4'h0;
  localparam logic [STAGE_COUNT-1:0] COUNT_MAX   = 4'hF;
  localparam logic [STAGE_COUNT-1:0] COUNT_MIN   = 4'h0;
  localparam int TOP_STAGE   = 3;
  // Select codes written as {bit2, bit1, bit0}
  localparam logic [2:0] SEL_LOAD       = 3'h0;
  localparam logic [2:0] SEL_SHIFT_DOWN = 3'h2;
  localparam logic [2:0] SEL_SHIFT_UP   = 3'h3;
  localparam logic [2:0] SEL_COUNT_DOWN = 3'h4;
  localparam logic [2:0] SEL_COUNT_UP   = 3'h6;
  localparam logic [2:0] SEL_HOLD       = 3'h7;
  localparam logic [2:0] SEL_COMPLEMENT = 3'h1;
  localparam logic [2:0] SEL_CLEAR      = 3'h5;

  typedef enum {
    OP_LOAD, OP_SHIFT_DOWN, OP_SHIFT_UP, OP_COUNT_DOWN,
    OP_COUNT_UP, OP_HOLD, OP_COMPLEMENT, OP_CLEAR
  } stage_op_t;
endpackage : counter_shift_pkg

// ==== rtl/function_decoder.sv ====
// Decoder from the three select inputs to one stage operation.
// Purely combinational; the caller feeds its result straight into its next-state logic.
`timescale 1ns/1ps
module function_decoder
  import counter_shift_pkg::*;
(
  // Select in
  input  wire logic [counter_shift_pkg::SEL_WIDTH-1:0] function_select,
  // Operation out
  output counter_shift_pkg::stage_op_t                 stage_op
);
  always_comb begin
    case (function_select) // RULE1
      SEL_LOAD:       stage_op = OP_LOAD;
      SEL_SHIFT_DOWN: stage_op = OP_SHIFT_DOWN;
      SEL_SHIFT_UP:   stage_op = OP_SHIFT_UP;
      SEL_COUNT_DOWN: stage_op = OP_COUNT_DOWN;
      SEL_COUNT_UP:   stage_op = OP_COUNT_UP;
      SEL_HOLD:       stage_op = OP_HOLD;
      SEL_COMPLEMENT: stage_op = OP_COMPLEMENT;
      SEL_CLEAR:      stage_op = OP_CLEAR;
      default:        stage_op = OP_HOLD;
    endcase
  end
endmodule // function_decoder

// ==== rtl/counter_shift_stage.sv ====
// Four-stage up/down counter and bidirectional shift register, one clock.
// Assumes inputs synchronous to clk_sys; master_clear is taken asynchronously.
//
// Overview of operation
// (RULE1) Three select bits pick eight operations
// (RULE2) Counting wraps modulo sixteen, up or down
// (RULE3) Count only when both enables are low
// (RULE4) Shift up takes serial bit from trickle enable
// (RULE5) Shift down takes serial bit from top input
// (RULE6) Terminal count low at 15 up, 0 down
// (RULE7) In shifts terminal count mirrors top stage
// (RULE8) Load captures the four preset inputs
// (RULE9) Master clear zeroes stages at once
// (RULE10) Complement inverts every stage on the edge
// (RULE11) Next stage links enable to this terminal count
// (RULE12) Updates on rising edge; hold keeps state
// (RULE13) Clear function zeroes stages regardless of enables
`timescale 1ns/1ps
module counter_shift_stage
  import counter_shift_pkg::*;
#(
  parameter int WIDTH = counter_shift_pkg::STAGE_COUNT
) (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    reset_n,
  // Control
  input  wire logic [counter_shift_pkg::SEL_WIDTH-1:0] function_select,
  input  wire logic                                    parallel_count_enable_n,
  input  wire logic                                    trickle_count_enable_n,
  input  wire logic                                    serial_down_input,
  input  wire logic                                    master_clear,
  // Data
  input  wire logic [WIDTH-1:0]                        preset_inputs,
  output logic      [WIDTH-1:0]                        stage_q,
  output logic                                         top_stage_output,
  output logic                                         terminal_count_n
);
  import counter_shift_pkg::*;

  stage_op_t        stage_op;
  logic [WIDTH-1:0] state_q;
  logic [WIDTH-1:0] state_d;
  logic             term_n_q;
  logic             term_n_d;
  logic             count_ok;

  function_decoder u_decoder (
    .function_select (function_select),
    .stage_op        (stage_op)
  );

  // Terminal count is decoded from the next state and registered, so that the
  // output still comes from a flop yet tracks the stages with no lag.
  function automatic logic term_of(input stage_op_t op, input logic [WIDTH-1:0] st);
    logic r;
    r = 1'b1;
    case (op)
      OP_COUNT_UP:   r = ~(st == WIDTH'(COUNT_MAX)); // RULE6
      OP_COUNT_DOWN: r = ~(st == WIDTH'(COUNT_MIN)); // RULE6
      OP_SHIFT_UP,
      OP_SHIFT_DOWN: r = st[WIDTH-1]; // RULE7 RULE11
      default:       r = 1'b1;
    endcase
    return r;
  endfunction

  assign count_ok = ~parallel_count_enable_n & ~trickle_count_enable_n; // RULE3

  always_comb begin
    state_d = state_q;
    case (stage_op)
      OP_LOAD:       state_d = preset_inputs; // RULE8
      OP_SHIFT_DOWN: state_d = {serial_down_input, state_q[WIDTH-1:1]}; // RULE5
      OP_SHIFT_UP:   state_d = {state_q[WIDTH-2:0], trickle_count_enable_n}; // RULE4
      OP_COUNT_UP:   if (count_ok) state_d = state_q + WIDTH'(1); // RULE2 RULE3
      OP_COUNT_DOWN: if (count_ok) state_d = state_q - WIDTH'(1); // RULE2 RULE3
      OP_COMPLEMENT: state_d = ~state_q; // RULE10
      OP_CLEAR:      state_d = '0; // RULE13
      OP_HOLD:       state_d = state_q; // RULE12
      default:       state_d = state_q;
    endcase
    term_n_d = term_of(stage_op, state_d);
  end

  // Master clear and system reset share the async path; both force zero.
  // Trade-off: master_clear is combined into the async reset, so it must be
  // glitch-free in the system that drives it.
  // Terminal count rests high under either clear, as for any op outside count/shift.
  always_ff @(posedge clk_sys or negedge reset_n or posedge master_clear) begin // RULE12
    if (!reset_n || master_clear) begin // RULE9
      state_q <= WIDTH'(STATE_RESET);
      term_n_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      term_n_q <= term_n_d;
    end
  end

  assign stage_q          = state_q;
  assign top_stage_output = state_q[WIDTH-1];
  assign terminal_count_n = term_n_q;

  // Assertions
  // Guard for properties that look one edge back; only reset_n restarts it
  logic [1:0] past_valid_q;
  logic [1:0] past_valid_d;

  always_comb begin
    past_valid_d = past_valid_q;
    if (past_valid_q != 2'h3) begin
      past_valid_d = past_valid_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      past_valid_q <= 2'h0;
    end else begin
      past_valid_q <= past_valid_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n || master_clear);

  // Each select code checked against its effect, past the decoder
  sel_load_a: assert property ( // RULE1
    function_select == SEL_LOAD |=> stage_q == $past(preset_inputs))
    else $error("load code misdecoded");
  sel_sdown_a: assert property ( // RULE1
    function_select == SEL_SHIFT_DOWN
    |=> stage_q == {$past(serial_down_input), $past(stage_q[WIDTH-1:1])})
    else $error("shift down code misdecoded");
  sel_sup_a: assert property ( // RULE1
    function_select == SEL_SHIFT_UP
    |=> stage_q == {$past(stage_q[WIDTH-2:0]), $past(trickle_count_enable_n)})
    else $error("shift up code misdecoded");
  sel_cdown_a: assert property ( // RULE1
    function_select == SEL_COUNT_DOWN && count_ok
    |=> stage_q == $past(stage_q) - WIDTH'(1)) else $error("count down code misdecoded");
  sel_cup_a: assert property ( // RULE1
    function_select == SEL_COUNT_UP && count_ok
    |=> stage_q == $past(stage_q) + WIDTH'(1)) else $error("count up code misdecoded");
  sel_hold_a: assert property ( // RULE1
    function_select == SEL_HOLD |=> $stable(stage_q)) else $error("hold code misdecoded");
  sel_compl_a: assert property ( // RULE1
    function_select == SEL_COMPLEMENT |=> stage_q == ~$past(stage_q))
    else $error("complement code misdecoded");
  sel_clear_a: assert property ( // RULE1
    function_select == SEL_CLEAR |=> stage_q == '0) else $error("clear code misdecoded");

  // Counting and its inhibit
  count_up_step_a: assert property ( // RULE2
    past_valid_q != 0 && stage_op == OP_COUNT_UP && count_ok
    |=> stage_q == $past(stage_q) + WIDTH'(1)) else $error("count up step wrong");
  count_dn_step_a: assert property ( // RULE2
    past_valid_q != 0 && stage_op == OP_COUNT_DOWN && count_ok
    |=> stage_q == $past(stage_q) - WIDTH'(1)) else $error("count down step wrong");
  wrap_up_a: assert property ( // RULE2
    stage_op == OP_COUNT_UP && count_ok && stage_q == WIDTH'(COUNT_MAX)
    |=> stage_q == WIDTH'(COUNT_MIN)) else $error("count up did not wrap");
  wrap_down_a: assert property ( // RULE2
    stage_op == OP_COUNT_DOWN && count_ok && stage_q == WIDTH'(COUNT_MIN)
    |=> stage_q == WIDTH'(COUNT_MAX)) else $error("count down did not wrap");
  count_inhibit_a: assert property ( // RULE3
    past_valid_q != 0 && !count_ok
    && (stage_op == OP_COUNT_UP || stage_op == OP_COUNT_DOWN)
    |=> $stable(stage_q)) else $error("count not inhibited");

  // Terminal count follows the op taken at the last edge
  term_count_a: assert property ( // RULE6
    stage_op == OP_COUNT_UP ##1 stage_op == OP_COUNT_UP && count_ok
    |=> terminal_count_n == (stage_q != WIDTH'(COUNT_MAX)))
    else $error("terminal count wrong");
  term_up_a: assert property ( // RULE6
    stage_op == OP_COUNT_UP
    |=> terminal_count_n == (stage_q != WIDTH'(COUNT_MAX)))
    else $error("terminal count wrong after count up");
  term_down_a: assert property ( // RULE6
    stage_op == OP_COUNT_DOWN
    |=> terminal_count_n == (stage_q != WIDTH'(COUNT_MIN)))
    else $error("terminal count wrong after count down");
  term_idle_a: assert property ( // RULE6
    stage_op inside {OP_LOAD, OP_HOLD, OP_COMPLEMENT, OP_CLEAR}
    |=> terminal_count_n) else $error("terminal count low outside count and shift");
  term_shift_a: assert property ( // RULE7
    stage_op == OP_SHIFT_UP || stage_op == OP_SHIFT_DOWN
    |=> terminal_count_n == top_stage_output) else $error("terminal count not top stage");

  // Shifts, load, complement, hold and clear
  shift_up_in_a: assert property ( // RULE4
    stage_op == OP_SHIFT_UP
    |=> stage_q[0] == $past(trickle_count_enable_n)
        && stage_q[WIDTH-1:1] == $past(stage_q[WIDTH-2:0]))
    else $error("shift up wrong");
  shift_dn_in_a: assert property ( // RULE5
    stage_op == OP_SHIFT_DOWN
    |=> stage_q[WIDTH-1] == $past(serial_down_input)
        && stage_q[WIDTH-2:0] == $past(stage_q[WIDTH-1:1]))
    else $error("shift down wrong");
  load_cap_a: assert property ( // RULE8
    stage_op == OP_LOAD |=> stage_q == $past(preset_inputs)) else $error("load failed");
  complement_a: assert property ( // RULE10
    stage_op == OP_COMPLEMENT |=> stage_q == ~$past(stage_q)) else $error("complement failed");
  hold_keep_a: assert property ( // RULE12
    stage_op == OP_HOLD |=> $stable(stage_q)) else $error("hold changed state");
  clear_sync_a: assert property ( // RULE13
    stage_op == OP_CLEAR |=> stage_q == '0) else $error("clear failed");
  clear_enables_a: assert property ( // RULE13
    stage_op == OP_CLEAR && !count_ok
    |=> stage_q == '0) else $error("clear waited on the enables");

  // Master clear acts between edges, so only reset_n may disable these
  mclr_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
    master_clear |-> stage_q == '0) else $error("master clear ignored");
  mclr_term_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
    master_clear |-> terminal_count_n) else $error("terminal count low under master clear");

  wrap_up_c: cover property (
    stage_op == OP_COUNT_UP && count_ok && stage_q == WIDTH'(COUNT_MAX));
  wrap_down_c: cover property (
    stage_op == OP_COUNT_DOWN && count_ok && stage_q == '0);
  shift_up_c: cover property (stage_op == OP_SHIFT_UP [*2]);
  shift_down_c: cover property (stage_op == OP_SHIFT_DOWN [*2]);
  mclr_c: cover property (@(posedge clk_sys) disable iff (!reset_n) master_clear);
endmodule // counter_shift_stage

// ==== sim/lower_stage_model.sv ====
// Behavioural lower stage of a cascade, driving the link into the trickle enable.
// Assumes the bench sets next_bit away from the falling edge of clk_sys.
`timescale 1ns/1ps
module lower_stage_model (
  // Clock
  input  wire logic clk_sys,
  // Link
  input  wire logic next_bit,
  output logic      link_n
);
  initial link_n = 1'b1;
  // Moves on the falling edge so the upper stage sees a settled level
  always @(negedge clk_sys) link_n <= next_bit;
endmodule // lower_stage_model

// ==== sim/four_stage_counter_shift_register_test.sv ====
// Self-checking bench for the four-stage counter / shift register.
// Assumes a 40 ns clock; the trickle enable comes through the lower stage model.
`timescale 1ns/1ps
module four_stage_counter_shift_register_test;
  import counter_shift_pkg::*;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic [2:0] function_select = SEL_HOLD;
  logic       pe_n = 1'b0, nb = 1'b0, sd = 1'b0, master_clear = 1'b0;
  logic [3:0] preset_inputs = 4'h0;
  logic [3:0] stage_q;
  logic       link_n, top_stage_output, terminal_count_n;
  int         error_cnt = 0, tests_run = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  // Whole run needs well under a hundred edges
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 400) begin
      error_cnt++;
      print_verdict();
    end
  end
  lower_stage_model lower (.clk_sys(clk_sys), .next_bit(nb), .link_n(link_n));
  counter_shift_stage uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .function_select(function_select), .parallel_count_enable_n(pe_n),
    .trickle_count_enable_n(link_n), .serial_down_input(sd), .master_clear(master_clear),
    .preset_inputs(preset_inputs), .stage_q(stage_q), .top_stage_output(top_stage_output),
    .terminal_count_n(terminal_count_n));
  task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One operation: link bit set mid-cycle, controls at the falling edge, check after the rise
  task step(input logic [2:0] s, input logic pe, input logic t, input logic d,
            input logic [3:0] p, input logic [3:0] q, input logic term);
    nb <= t;
    @(negedge clk_sys);
    function_select <= s;
    pe_n <= pe;
    sd <= d;
    preset_inputs <= p;
    @(posedge clk_sys);
    #10;
    chk("stage", q, stage_q);
    chk("terminal", {3'h0, term}, {3'h0, terminal_count_n});
    chk("top", {3'h0, q[3]}, {3'h0, top_stage_output});
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    chk("reset stage", 4'h0, stage_q);
    @(negedge clk_sys);
    reset_n <= 1'b1;
    // Load ignores the enables; count up wraps and flags fifteen
    step(SEL_LOAD, 1'b1, 1'b1, 1'b0, 4'hB, 4'hB, 1'b1);
    step(SEL_LOAD, 1'b0, 1'b0, 1'b0, 4'hE, 4'hE, 1'b1);
    step(SEL_COUNT_UP, 1'b0, 1'b0, 1'b0, 4'h0, 4'hF, 1'b0);
    step(SEL_COUNT_UP, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b1);
    step(SEL_COUNT_UP, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 1'b1);
    step(SEL_COUNT_UP, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0, 1'b1);
    $display("count up test done");
    step(SEL_COUNT_DOWN, 1'b0, 1'b0, 1'b0, 4'h0, 4'hF, 1'b1);
    step(SEL_LOAD, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 1'b1);
    step(SEL_COUNT_DOWN, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0);
    $display("count down test done");
    step(SEL_LOAD, 1'b0, 1'b0, 1'b0, 4'h5, 4'h5, 1'b1);
    step(SEL_SHIFT_UP, 1'b1, 1'b1, 1'b0, 4'h0, 4'hB, 1'b1);
    step(SEL_SHIFT_UP, 1'b1, 1'b0, 1'b1, 4'h0, 4'h6, 1'b0);
    step(SEL_SHIFT_DOWN, 1'b1, 1'b1, 1'b1, 4'h0, 4'hB, 1'b1);
    step(SEL_SHIFT_DOWN, 1'b1, 1'b1, 1'b0, 4'h0, 4'h5, 1'b0);
    $display("shift test done");
    step(SEL_COMPLEMENT, 1'b1, 1'b1, 1'b0, 4'h0, 4'hA, 1'b1);
    step(SEL_HOLD, 1'b0, 1'b0, 1'b0, 4'h3, 4'hA, 1'b1);
    step(SEL_CLEAR, 1'b1, 1'b1, 1'b0, 4'h0, 4'h0, 1'b1);
    step(SEL_LOAD, 1'b0, 1'b0, 1'b0, 4'hF, 4'hF, 1'b1);
    // Master clear checked before any rising edge can act
    @(negedge clk_sys);
    function_select <= SEL_HOLD;
    master_clear <= 1'b1;
    #5;
    chk("clear stage", 4'h0, stage_q);
    chk("clear terminal", 4'h1, {3'h0, terminal_count_n});
    @(negedge clk_sys);
    master_clear <= 1'b0;
    step(SEL_HOLD, 1'b0, 1'b0, 1'b0, 4'h7, 4'h0, 1'b1);
    $display("complement and clear test done");
    print_verdict();
  end
endmodule // four_stage_counter_shift_register_test
